// ===== src/sarseq_top.sv
`timescale 1ns/1ps
// Functional notes
// - Rising write strobe with chip select starts tracking.
// - Host-timed mode: next write rising edge with the acquisition bit clear holds and starts conversion.
// - Self-timed mode: hold on fourth falling conversion-clock edge.
// - Every conversion takes 13 conversion-clock cycles.
// - Control write during conversion abandons it; normal-mode codes restart acquisition.
// - Acquisition bit zero: timed acquisition then automatic conversion.
// - Single-ended: selected channel positive, common reference negative.
// - Pseudo-differential: both inputs from a selected channel pair.
// - Result is 10 bits, delivered as a byte plus two bits.
// - Conversion start moves hold capacitor to negative input, then SAR.
// - After conversion hold capacitor returns to positive input.
// - Byte: bit5 acquisition, bit4 single-ended, bit3 unipolar, 2:0 ch.
// - Top bits: power-down, standby, internal clock, external clock.
// - Completion flag low on result, released on read or write.
// - Byte select low gives low eight bits, high gives upper two.
module sarseq_top
  import sarseq_pkg::*;
#(
  parameter int RES_BITS = 10,
  parameter int CH_BITS = 3
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic upper_byte_select,
  input wire logic conv_clk,
  input wire logic [7:0] data_in,
  input wire logic comp_out,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic int_n,
  output logic int_n_oe,
  output sarseq_mux_t mux_q,
  output logic [RES_BITS-1:0] dac_code,
  output logic [1:0] power_state
);

  typedef enum logic [1:0] {S_IDLE, S_ACQ, S_CONV} sarseq_state_t;

  // Pin synchronisers; the second stage and the third (previous value) are read by logic.
  logic [4:0] s1_q, s2_q, s3_q;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q <= 5'h1f;
      s2_q <= 5'h1f;
      s3_q <= 5'h1f;
    end
    else
    begin
      s1_q <= {cs_n, wr_n, rd_n, conv_clk, upper_byte_select};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  logic cs_s, wr_s, rd_s, cclk_s, ube_s, wr_prev, rd_prev, cclk_prev;
  assign cs_s = ~s2_q[4];
  assign wr_s = s2_q[3];
  assign rd_s = s2_q[2];
  assign cclk_s = s2_q[1];
  assign ube_s = s2_q[0];
  assign wr_prev = s3_q[3];
  assign rd_prev = s3_q[2];
  assign cclk_prev = s3_q[1];

  // Data byte is sampled alongside the strobe so it is stable at the edge.
  logic [7:0] din1_q, din2_q;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      din1_q <= 8'h00;
      din2_q <= 8'h00;
    end
    else
    begin
      din1_q <= data_in;
      din2_q <= din1_q;
    end
  end

  logic wr_rise, rd_fall, ext_fall, ext_rise;
  assign wr_rise = cs_s & wr_s & ~wr_prev;
  assign rd_fall = cs_s & ~rd_s & rd_prev;
  assign ext_fall = ~cclk_s & cclk_prev;
  assign ext_rise = cclk_s & ~cclk_prev;

  // Internal oscillator: a divider gives both edges of a slow clock.
  logic [7:0] osc_cnt_q, osc_cnt_d;
  logic osc_q, osc_d, int_fall, int_rise;
  always_comb
  begin
    osc_cnt_d = osc_cnt_q + 8'h01;
    osc_d = osc_q;
    if (osc_cnt_q == 8'(INT_DIV / 2 - 1))
    begin
      osc_cnt_d = 8'h00;
      osc_d = ~osc_q;
    end
  end
  assign int_fall = osc_q & ~osc_d;
  assign int_rise = ~osc_q & osc_d;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      osc_cnt_q <= 8'h00;
      osc_q <= 1'b0;
    end
    else
    begin
      osc_cnt_q <= osc_cnt_d;
      osc_q <= osc_d;
    end
  end

  // Control byte and clock mode; power-down codes keep the last clock mode.
  sarseq_ctrl_t ctrl_q, ctrl_d;
  logic ext_clk_q, ext_clk_d;
  always_comb
  begin
    ctrl_d = ctrl_q;
    ext_clk_d = ext_clk_q;
    if (wr_rise)
    begin
      ctrl_d = sarseq_ctrl_t'(din2_q);
      if (din2_q[CB_PWR_HI])
        ext_clk_d = din2_q[CB_PWR_LO];
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q <= sarseq_ctrl_t'(CTRL_RESET);
      ext_clk_q <= CTRL_RESET[CB_PWR_LO];
    end
    else
    begin
      ctrl_q <= ctrl_d;
      ext_clk_q <= ext_clk_d;
    end
  end

  // Conversion-clock edges follow the selected source.
  logic ck_fall, ck_rise;
  assign ck_fall = ext_clk_q ? ext_fall : int_fall;
  assign ck_rise = ext_clk_q ? ext_rise : int_rise;

  // Sequencer: track, hold, convert, and result hand-off.
  sarseq_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [RES_BITS-1:0] sar_q, sar_d, res_q, res_d;
  logic done_q, done_d;
  logic host_hold;
  logic [3:0] bit_idx;
  assign bit_idx = 4'(RES_BITS) - cnt_q;
  // Host-timed hold: a write with the acquisition bit clear, while the stored byte has the acquisition bit set.
  assign host_hold = wr_rise & ctrl_q.acq_mode_bit & (st_q == S_ACQ)
    & ~din2_q[CB_ACQ];

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    sar_d = sar_q;
    res_d = res_q;
    done_d = done_q;
    if (rd_fall)
      done_d = 1'b1;
    if (host_hold)
    begin
      done_d = 1'b1;
      st_d = S_CONV;
      cnt_d = 4'h0;
      sar_d = '0;
    end
    else if (wr_rise)
    begin
      done_d = 1'b1;
      st_d = S_ACQ;
      cnt_d = 4'h0;
      if (!din2_q[CB_PWR_HI])
        st_d = S_IDLE;
    end
    else
    begin
      unique case (st_q)
        S_IDLE: ;
        S_ACQ:
          if (!ctrl_q.acq_mode_bit && ck_fall)
          begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == 4'(ACQ_FALL_EDGES - 1))
            begin
              st_d = S_CONV;
              cnt_d = 4'h0;
              sar_d = '0;
            end
          end
        S_CONV:
          if (ck_rise)
          begin
            cnt_d = cnt_q + 4'h1;
            // First cycle moves the capacitor; then one bit per cycle.
            if (cnt_q >= 4'h1 && cnt_q <= 4'(RES_BITS))
            begin
              sar_d[bit_idx] = comp_out;
            end
            if (cnt_q == 4'(CONV_CYCLES - 1))
            begin
              st_d = S_IDLE;
              res_d = sar_q;
              done_d = 1'b0;
            end
          end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= S_IDLE;
      cnt_q <= 4'h0;
      sar_q <= '0;
      res_q <= '0;
      done_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sar_q <= sar_d;
      res_q <= res_d;
      done_q <= done_d;
    end
  end

  // Trial code for the DAC: resolved bits plus the bit under test.
  logic [RES_BITS-1:0] trial;
  always_comb
  begin
    trial = sar_q;
    if (st_q == S_CONV && cnt_q >= 4'h1 && cnt_q <= 4'(RES_BITS))
      trial[bit_idx] = 1'b1;
  end

  // Multiplexer routing; pairs share the upper channel bits.
  sarseq_mux_t mux_d;
  always_comb
  begin
    mux_d.pos_ch = ctrl_q.channel_addr;
    mux_d.neg_ch = ctrl_q.channel_addr ^ 3'h1;
    mux_d.neg_is_com = ctrl_q.single_ended_sel;
    mux_d.track = (st_q == S_ACQ);
    mux_d.hold_capacitor_neg = (st_q == S_CONV);
    mux_d.sar_active = (st_q == S_CONV);
  end

  // Read port: bytes are muxed from the held result.
  logic [7:0] dout_d;
  always_comb
  begin
    if (ube_s)
      dout_d = {6'h00, res_q[RES_BITS-1:8]};
    else
      dout_d = res_q[7:0];
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
      int_n <= 1'b1;
      int_n_oe <= 1'b0;
      mux_q <= '0;
      dac_code <= '0;
      power_state <= CTRL_RESET[CB_PWR_HI:CB_PWR_LO];
    end
    else
    begin
      data_out <= dout_d;
      data_oe <= cs_s & ~rd_s;
      int_n <= done_q;
      int_n_oe <= cs_s;
      mux_q <= mux_d;
      dac_code <= trial;
      power_state <= ctrl_q.power_clock_mode;
    end
  end

  // Assertions.
  conv_length_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_q == S_CONV && !wr_rise && !(ck_rise && cnt_q == 4'(CONV_CYCLES - 1)))
    |=> st_q == S_CONV)
    else $error("conversion ended too early");
  conv_end_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_q == S_CONV && ck_rise && !wr_rise && cnt_q == 4'(CONV_CYCLES - 1))
    |=> st_q == S_IDLE && !done_q)
    else $error("conversion did not finish on its last cycle");
  write_restart_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr_rise && !host_hold && din2_q[CB_PWR_HI]) |=> st_q == S_ACQ)
    else $error("write did not restart acquisition");
  flag_release_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr_rise || (rd_fall && st_q != S_CONV)) |-> ##2 int_n)
    else $error("completion flag not released");
  byte_sel_a: assert property (@(posedge clk) disable iff (!nrst)
    ube_s |=> data_out[7:2] == 6'h00)
    else $error("upper byte has stray bits");
  cap_return_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_q == S_IDLE) |=> !mux_q.hold_capacitor_neg)
    else $error("hold capacitor not returned");
  host_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    host_hold |=> st_q == S_CONV && cnt_q == 4'h0)
    else $error("host hold did not start conversion");
  acq_track_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_q == S_ACQ) |=> mux_q.track)
    else $error("not tracking in acquisition");
  self_acq_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_q == S_ACQ && !ctrl_q.acq_mode_bit && ck_fall && !wr_rise
     && cnt_q == 4'(ACQ_FALL_EDGES - 1)) |=> st_q == S_CONV)
    else $error("self-timed hold missed");

endmodule // sarseq_top

// ===== src/sarseq_pkg.sv
package sarseq_pkg;

  // Control byte field positions.
  localparam int CB_PWR_HI = 7;
  localparam int CB_PWR_LO = 6;
  localparam int CB_ACQ = 5;
  localparam int CB_SGL = 4;
  localparam int CB_UNI = 3;
  localparam int CB_CH_HI = 2;

  // Power and clock mode codes of the two top bits.
  localparam logic [1:0] PM_FULL_DOWN = 2'h0;
  localparam logic [1:0] PM_STANDBY = 2'h1;
  localparam logic [1:0] PM_NORM_INT = 2'h2;
  localparam logic [1:0] PM_NORM_EXT = 2'h3;

  // Timing counts in conversion-clock cycles.
  localparam int ACQ_FALL_EDGES = 4;
  localparam int CONV_CYCLES = 13;

  // Internal oscillator period; 3.6 us over 13 cycles gives about 277 ns.
  localparam int INT_CLK_NS = 277;
  localparam int CLK_NS = 5;
  localparam int INT_DIV = (INT_CLK_NS + CLK_NS - 1) / CLK_NS;

  // Reset values: external clock mode at power-up.
  localparam logic [7:0] CTRL_RESET = 8'hf0;

  typedef struct packed {
    logic [1:0] power_clock_mode;
    logic acq_mode_bit;
    logic single_ended_sel;
    logic unipolar_sel;
    logic [2:0] channel_addr;
  } sarseq_ctrl_t;

  // Analog multiplexer and switch controls.
  typedef struct packed {
    logic [2:0] pos_ch;
    logic [2:0] neg_ch;
    logic neg_is_com;
    logic track;
    logic hold_capacitor_neg;
    logic sar_active;
  } sarseq_mux_t;

endpackage

// ===== sim/sarseq_host.sv
`timescale 1ns/1ps
// Host model: drives the byte-wide port and stands in for the comparator.
module sarseq_host
  import sarseq_pkg::*;
(
  input wire logic clk,
  input wire logic [9:0] dac_code,
  input wire logic [7:0] data_out,
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic upper_byte_select,
  output logic conv_clk,
  output logic [7:0] data_in,
  output logic comp_out
);
  logic [9:0] target;
  int ph;

  // Idle bus at time zero; the pin clock runs free.
  initial
  begin
    {cs_n, wr_n, rd_n, upper_byte_select, conv_clk} = 5'h1c;
    data_in = 8'h00;
    target = 10'h000;
    ph = 0;
  end

  // Conversion clock of 28 system clocks; a faster pin clock is not allowed.
  always @(posedge clk)
  begin
    ph <= (ph == 13) ? 0 : ph + 1;
    if (ph == 13)
      conv_clk <= ~conv_clk;
  end

  // A trial at or below the held input keeps its bit.
  assign comp_out = (dac_code <= target);

  // Control byte is settled five cycles before the strobe rises.
  task automatic wr(input logic [7:0] b);
    @(posedge clk);
    cs_n <= 1'b0;
    data_in <= b;
    repeat (3) @(posedge clk);
    wr_n <= 1'b0;
    repeat (2) @(posedge clk);
    wr_n <= 1'b1;
    repeat (3) @(posedge clk);
    cs_n <= 1'b1;
    data_in <= ~b; // A released bus must not keep its last value.
  endtask

  // Read one result byte; the selector settles before sampling.
  task automatic rd(input logic ub, output logic [7:0] v);
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    upper_byte_select <= ub;
    repeat (6) @(posedge clk);
    v = data_out;
    rd_n <= 1'b1;
    cs_n <= 1'b1;
  endtask
endmodule // sarseq_host

// ===== sim/test_sar_adc_acquisition_sequencer.sv
`timescale 1ns/1ps
// Self-checking bench of the acquisition sequencer.
module test_sar_adc_acquisition_sequencer;
  import sarseq_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cs_n, wr_n, rd_n, upper_byte_select, conv_clk, comp_out;
  logic data_oe, int_n, int_n_oe;
  logic [7:0] data_in, data_out, v;
  logic [9:0] dac_code, t;
  logic [1:0] power_state;
  sarseq_mux_t mux_q;
  logic [31:0] seed = 32'h00015b9b;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  int rises = 0;
  int i;

  sarseq_top i_sarseq_top (.clk, .nrst, .cs_n, .wr_n, .rd_n,
    .upper_byte_select, .conv_clk, .data_in, .comp_out, .data_out,
    .data_oe, .int_n, .int_n_oe, .mux_q, .dac_code, .power_state);

  sarseq_host i_host (.clk, .dac_code, .data_out, .cs_n, .wr_n, .rd_n,
    .upper_byte_select, .conv_clk, .data_in, .comp_out);

  // Clock generation and hang guard.
  initial
  begin
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_count++;
      test_done();
    end
  end

  // Conversion clock rises seen since the last write.
  always @(posedge conv_clk)
    rises++;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Write, check routing, wait for completion, read both halves.
  task automatic convert(input logic [7:0] b, input logic h,
                         input int lo, input int hi);
    int k;
    t = seed[9:0];
    i_host.target = t;
    rises = 0;
    i_host.wr(b);
    repeat (2) @(negedge clk);
    chk(mux_q.track, !h);
    chk(mux_q.pos_ch, b[2:0]);
    if (b[4])
      chk(mux_q.neg_is_com, 1'b1);
    else
      chk(mux_q.neg_ch, b[2:0] ^ 3'h1);
    for (k = 0; k < 3000 && int_n !== 1'b0; k++)
      @(negedge clk);
    chk(int_n, 1'b0);
    chk(rises >= lo && rises <= hi, 1'b1);
    chk(mux_q.hold_capacitor_neg, 1'b0);
    i_host.rd(1'b0, v);
    chk(v, t[7:0]);
    chk(data_oe, 1'b1);
    chk(int_n_oe, 1'b1);
    chk(int_n, 1'b1);
    i_host.rd(1'b1, v);
    chk(v, {6'h00, t[9:8]});
  endtask

  // Main sequence.
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    chk(power_state, 2'h3);
    chk(data_oe, 1'b0);
    chk(int_n_oe, 1'b0);
    chk(int_n, 1'b1);
    for (i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      if (i[0])
        convert({2'h2, 1'b0, seed[14:10]}, 1'b0, 30, 70);
      else
        convert({2'h3, 1'b0, seed[14:10]}, 1'b0, 15, 18);
    end
    // Host-timed: no hold until the second write.
    seed = xs(seed);
    i_host.wr(8'hf5);
    repeat (200) @(negedge clk);
    chk(mux_q.track, 1'b1);
    chk(mux_q.sar_active, 1'b0);
    convert(8'hd5, 1'b1, 12, 15);
    // Abort a running conversion with a fresh write.
    i_host.wr(8'hd2);
    for (i = 0; i < 400 && mux_q.sar_active !== 1'b1; i++)
      @(negedge clk);
    chk(mux_q.hold_capacitor_neg, 1'b1);
    seed = xs(seed);
    convert(8'hc3, 1'b0, 15, 18);
    chk(mux_q.sar_active, 1'b0);
    // Power-down codes idle the converter.
    for (i = 0; i < 2; i++)
    begin
      i_host.wr({i[1:0], 6'h10});
      repeat (3) @(negedge clk);
      chk(power_state, i[1:0]);
    end
    test_done();
  end
endmodule // test_sar_adc_acquisition_sequencer
